// file: liu_regs_pkg.sv
// constants, register map and state codes of the line interface register bank
package liu_regs_pkg;

   // ***************************************************************
   // channel count and address layout
   // ***************************************************************
   localparam int           NUM_CHAN         = 6;       // six line channels
   localparam logic [3:0]   CHAN_LIMIT       = 4'h6;    // upper nibble below this is a channel block
   localparam logic [7:0]   ADDR_TX_ENABLE   = 8'h00;   // transmit_enable_per_channel
   localparam logic [7:0]   ADDR_RX_ENABLE   = 8'h08;   // receive_enable_per_channel
   localparam logic [7:0]   ADDR_GLOBAL_IEN  = 8'h60;   // global_interrupt_enable
   localparam logic [7:0]   ADDR_GLOBAL_PEND = 8'h61;   // global_interrupt_pending
   localparam logic [7:0]   ADDR_IDENTITY    = 8'h6E;   // device_identity
   localparam logic [7:0]   ADDR_VERSION     = 8'h6F;   // silicon_version

   // ***************************************************************
   // per-channel offsets inside a 16-byte block
   // ***************************************************************
   localparam logic [3:0]   OFS_GLOBAL_A     = 4'h0;    // holds a global in block 0
   localparam logic [3:0]   OFS_IRQ_ENABLE   = 4'h1;
   localparam logic [3:0]   OFS_IRQ_STATUS   = 4'h2;
   localparam logic [3:0]   OFS_ALARM        = 4'h3;
   localparam logic [3:0]   OFS_TX_CTRL      = 4'h4;
   localparam logic [3:0]   OFS_RX_CTRL      = 4'h5;
   localparam logic [3:0]   OFS_BLOCK_CTRL   = 4'h6;
   localparam logic [3:0]   OFS_JITTER_CTRL  = 4'h7;
   localparam logic [3:0]   OFS_GLOBAL_B     = 4'h8;    // holds a global in block 0
   localparam logic [3:0]   OFS_ERR_HIGH     = 4'hA;
   localparam logic [3:0]   OFS_ERR_LOW      = 4'hB;
   localparam logic [3:0]   OFS_ERR_HOLD     = 4'hC;

   // ***************************************************************
   // implemented-bit masks (reserved bits read zero)
   // ***************************************************************
   localparam logic [7:0]   MASK_CHAN6       = 8'h3F;
   localparam logic [7:0]   MASK_IRQ         = 8'h3F;
   localparam logic [7:0]   MASK_ALARM       = 8'h7F;
   localparam logic [7:0]   MASK_TX_CTRL     = 8'h37;
   localparam logic [7:0]   MASK_RX_CTRL     = 8'h3F;
   localparam logic [7:0]   MASK_BLOCK_CTRL  = 8'h7F;
   localparam logic [7:0]   MASK_JITTER_CTRL = 8'h1F;

   // ***************************************************************
   // reset values and counter limits
   // ***************************************************************
   localparam logic [7:0]   RESET_BYTE       = 8'h00;
   localparam logic [5:0]   RESET_CHAN6      = 6'h00;
   localparam logic [15:0]  ERR_COUNT_RESET  = 16'h0000;
   localparam logic [15:0]  ERR_COUNT_MAX    = 16'hFFFF;
   localparam logic [15:0]  ERR_COUNT_ONE    = 16'h0001;

   // ***************************************************************
   // timing: reset low time the controller must give
   // ***************************************************************
   localparam int           CLOCK_PERIOD_NS  = 10;
   localparam int           RESET_MIN_US     = 5;
   localparam int           RESET_MIN_CYCLES = (RESET_MIN_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

   // ***************************************************************
   // host port sequencer states
   // ***************************************************************
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,   // waiting for a strobe under select
      ST_ACK     = 2'b01,   // ready low until strobe released
      ST_WAIT_CS = 2'b10    // select must go high before next command
   } bus_state_t;

endpackage : liu_regs_pkg

// file: liu_chan_if.sv
// bundle between the host port decoder and one channel register block
`timescale 1ns/1ps
`default_nettype none
interface liu_chan_if;
   logic       wr_strobe;   // one-cycle write pulse
   logic       rd_strobe;   // one-cycle read pulse, drives clear-on-read
   logic [3:0] offset;      // offset inside the block
   logic [7:0] wdata;       // write data
   logic [7:0] rdata;       // read data for offset
   logic [7:0] tx_ctrl;     // transmit control
   logic [7:0] rx_ctrl;     // receive control
   logic [7:0] blk_ctrl;    // block control
   logic [7:0] ja_ctrl;     // jitter attenuator control
   logic       irq;         // any status bit set

   modport host (output wr_strobe, rd_strobe, offset, wdata,
                 input  rdata, tx_ctrl, rx_ctrl, blk_ctrl, ja_ctrl, irq);
   modport chan (input  wr_strobe, rd_strobe, offset, wdata,
                 output rdata, tx_ctrl, rx_ctrl, blk_ctrl, ja_ctrl, irq);
endinterface : liu_chan_if
`default_nettype wire

// file: liu_channel_regs.sv
// one channel register block: enables, sticky status, alarms, controls, test error count
`timescale 1ns/1ps
`default_nettype none
module liu_channel_regs (
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   // decoder side
   liu_chan_if.chan        bus,
   // line side conditions
   input  wire logic [6:0] alarm_in,
   input  wire logic       prbs_error_in
);

   // ***************************************************************
   // storage
   // ***************************************************************
   logic [7:0]  irq_enable_reg;   // source-level enables
   logic [7:0]  irq_status_reg;   // sticky change flags
   logic [7:0]  alarm_reg;        // last sampled alarm levels
   logic [7:0]  tx_ctrl_reg;
   logic [7:0]  rx_ctrl_reg;
   logic [7:0]  blk_ctrl_reg;
   logic [7:0]  ja_ctrl_reg;
   logic [15:0] err_count_reg;    // saturating error count
   logic [7:0]  err_hold_reg;     // low byte frozen on high-byte read
   logic [7:0]  events;           // enabled events this cycle
   logic        sat_event;        // count reaches saturation now

   // ***************************************************************
   // event detection
   // ***************************************************************
   // alarm bits 3:0 raise a flag on any change; error and saturation on pulse
   always_comb begin
      sat_event = prbs_error_in && (err_count_reg == (liu_regs_pkg::ERR_COUNT_MAX - liu_regs_pkg::ERR_COUNT_ONE));
      events    = {2'b00, sat_event, prbs_error_in, alarm_in[3:0] ^ alarm_reg[3:0]} & irq_enable_reg;
   end

   // control registers, writes to reserved bits dropped
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_enable_reg <= liu_regs_pkg::RESET_BYTE;
         tx_ctrl_reg    <= liu_regs_pkg::RESET_BYTE;
         rx_ctrl_reg    <= liu_regs_pkg::RESET_BYTE;
         blk_ctrl_reg   <= liu_regs_pkg::RESET_BYTE;
         ja_ctrl_reg    <= liu_regs_pkg::RESET_BYTE;
      end else if (bus.wr_strobe) begin
         case (bus.offset)
            liu_regs_pkg::OFS_IRQ_ENABLE:  irq_enable_reg <= bus.wdata & liu_regs_pkg::MASK_IRQ;
            liu_regs_pkg::OFS_TX_CTRL:     tx_ctrl_reg    <= bus.wdata & liu_regs_pkg::MASK_TX_CTRL;
            liu_regs_pkg::OFS_RX_CTRL:     rx_ctrl_reg    <= bus.wdata & liu_regs_pkg::MASK_RX_CTRL;
            liu_regs_pkg::OFS_BLOCK_CTRL:  blk_ctrl_reg   <= bus.wdata & liu_regs_pkg::MASK_BLOCK_CTRL;
            liu_regs_pkg::OFS_JITTER_CTRL: ja_ctrl_reg    <= bus.wdata & liu_regs_pkg::MASK_JITTER_CTRL;
            default: ;   // read-only or reserved
         endcase
      end
   end

   // alarm sampling, used for change detection and the alarm read
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         alarm_reg <= liu_regs_pkg::RESET_BYTE;
      end else begin
         alarm_reg <= {1'b0, alarm_in} & liu_regs_pkg::MASK_ALARM;
      end
   end

   // sticky status: a set in the clearing read cycle survives it
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         irq_status_reg <= liu_regs_pkg::RESET_BYTE;
      end else if (bus.rd_strobe && bus.offset == liu_regs_pkg::OFS_IRQ_STATUS) begin
         irq_status_reg <= events;
      end else begin
         irq_status_reg <= irq_status_reg | events;
      end
   end

   // error count saturates rather than wraps, so a huge burst stays visible
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         err_count_reg <= liu_regs_pkg::ERR_COUNT_RESET;
      end else if (prbs_error_in && err_count_reg != liu_regs_pkg::ERR_COUNT_MAX) begin
         err_count_reg <= err_count_reg + liu_regs_pkg::ERR_COUNT_ONE;
      end
   end

   // high-byte read freezes the low byte for a coherent 16-bit pair
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         err_hold_reg <= liu_regs_pkg::RESET_BYTE;
      end else if (bus.rd_strobe && bus.offset == liu_regs_pkg::OFS_ERR_HIGH) begin
         err_hold_reg <= err_count_reg[7:0];
      end
   end

   // ***************************************************************
   // read mux and outputs
   // ***************************************************************
   always_comb begin
      case (bus.offset)
         liu_regs_pkg::OFS_IRQ_ENABLE:  bus.rdata = irq_enable_reg;
         liu_regs_pkg::OFS_IRQ_STATUS:  bus.rdata = irq_status_reg;
         liu_regs_pkg::OFS_ALARM:       bus.rdata = alarm_reg;
         liu_regs_pkg::OFS_TX_CTRL:     bus.rdata = tx_ctrl_reg;
         liu_regs_pkg::OFS_RX_CTRL:     bus.rdata = rx_ctrl_reg;
         liu_regs_pkg::OFS_BLOCK_CTRL:  bus.rdata = blk_ctrl_reg;
         liu_regs_pkg::OFS_JITTER_CTRL: bus.rdata = ja_ctrl_reg;
         liu_regs_pkg::OFS_ERR_HIGH:    bus.rdata = err_count_reg[15:8];
         liu_regs_pkg::OFS_ERR_LOW:     bus.rdata = err_count_reg[7:0];
         liu_regs_pkg::OFS_ERR_HOLD:    bus.rdata = err_hold_reg;
         default:                       bus.rdata = liu_regs_pkg::RESET_BYTE;   // reserved reads zero
      endcase
   end

   assign bus.tx_ctrl  = tx_ctrl_reg;
   assign bus.rx_ctrl  = rx_ctrl_reg;
   assign bus.blk_ctrl = blk_ctrl_reg;
   assign bus.ja_ctrl  = ja_ctrl_reg;
   assign bus.irq      = |irq_status_reg;

endmodule : liu_channel_regs
`default_nettype wire

// file: liu_global_register_bank.sv
// top of the register bank: host port sequencer, global registers, six channel blocks
//
// Contract
// - reset release loads every register default
// - transmitter on only when bit and pin
// - receive enable bit turns receiver on
// - per-channel global interrupt enable at 0x60
// - pending bit per channel, cleared on read
// - read-only identity 0x6E and version 0x6F
// - alarm status bits set on change, error bits on pulse, clear on read
// - interrupt low until status cleared by reads or channel enable at 0x60 cleared
// - select, strobe low, ready low answers
`timescale 1ns/1ps
`default_nettype none
module liu_global_register_bank #(
   parameter logic [7:0] IDENTITY_CODE = 8'h5A,   // arbitrary value
   parameter logic [7:0] VERSION_CODE  = 8'h01    // arbitrary value
) (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   // host port
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe_out,
   input  wire logic        cs_n_in,
   input  wire logic        rd_n_in,
   input  wire logic        wr_n_in,
   output logic             rdy_n_out,
   output logic             int_n_out,
   // channel enables
   input  wire logic [5:0]  transmit_enable_pin_in,
   output logic      [5:0]  transmit_on_out,
   output logic      [5:0]  receive_on_out,
   // line side conditions, 7 alarm bits per channel
   input  wire logic [41:0] alarm_in,
   input  wire logic [5:0]  prbs_error_in,
   // channel control fields, 8 bits per channel
   output logic      [47:0] tx_control_out,
   output logic      [47:0] rx_control_out,
   output logic      [47:0] block_control_out,
   output logic      [47:0] jitter_control_out
);

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   // true when the address falls inside some channel block at an offset other than 0 or 8
   function automatic logic chan_hit(input logic [7:0] addr);
      chan_hit = (addr[7:4] < liu_regs_pkg::CHAN_LIMIT)
                 && (addr[3:0] != liu_regs_pkg::OFS_GLOBAL_A)
                 && (addr[3:0] != liu_regs_pkg::OFS_GLOBAL_B);
   endfunction : chan_hit

   // ***************************************************************
   // state and registers
   // ***************************************************************
   liu_regs_pkg::bus_state_t state_reg;   // host port sequencer
   logic [5:0] tx_enable_reg;             // transmit_on_bit per channel
   logic [5:0] rx_enable_reg;             // receive_on_bit per channel
   logic [5:0] global_ien_reg;            // channel_irq_enable_bit
   logic [5:0] global_pend_reg;           // channel_irq_pending_bit
   logic [7:0] data_reg;                  // captured read data
   logic       data_oe_reg;               // drive data while read acknowledged
   logic       rdy_n_reg;                 // ready, active low
   logic       int_n_reg;                 // interrupt, active low
   logic [5:0] transmit_on_reg;
   logic       rd_take;                   // read taken this cycle
   logic       wr_take;                   // write taken this cycle
   logic [7:0] read_mux;                  // value for the addressed register
   logic [7:0] chan_rdata [liu_regs_pkg::NUM_CHAN];
   logic [5:0] chan_irq;                  // per-channel status summary

   // ***************************************************************
   // host port sequencer
   // ***************************************************************
   // read wins when both strobes are low; one access per select
   always_comb begin
      rd_take = (state_reg == liu_regs_pkg::ST_IDLE) && !cs_n_in && !rd_n_in;
      wr_take = (state_reg == liu_regs_pkg::ST_IDLE) && !cs_n_in && rd_n_in && !wr_n_in;
   end

   // ready goes low one cycle after a strobe, stays until it is released
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_reg   <= liu_regs_pkg::ST_IDLE;
         rdy_n_reg   <= 1'b1;
         data_oe_reg <= 1'b0;
      end else begin
         case (state_reg)
            liu_regs_pkg::ST_IDLE: begin
               if (rd_take || wr_take) begin
                  state_reg   <= liu_regs_pkg::ST_ACK;
                  rdy_n_reg   <= 1'b0;
                  data_oe_reg <= rd_take;
               end
            end
            liu_regs_pkg::ST_ACK: begin
               if (rd_n_in && wr_n_in) begin   // strobe released ends the cycle
                  state_reg   <= cs_n_in ? liu_regs_pkg::ST_IDLE : liu_regs_pkg::ST_WAIT_CS;
                  rdy_n_reg   <= 1'b1;
                  data_oe_reg <= 1'b0;
               end
            end
            liu_regs_pkg::ST_WAIT_CS: begin
               if (cs_n_in) begin   // new command only after deselect
                  state_reg <= liu_regs_pkg::ST_IDLE;
               end
            end
            default: begin
               state_reg   <= liu_regs_pkg::ST_IDLE;
               rdy_n_reg   <= 1'b1;
               data_oe_reg <= 1'b0;
            end
         endcase
      end
   end

   // read data is captured at the take edge, before clear-on-read acts
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         data_reg <= liu_regs_pkg::RESET_BYTE;
      end else if (rd_take) begin
         data_reg <= read_mux;
      end
   end

   // ***************************************************************
   // global registers
   // ***************************************************************
   // enables written at their fixed addresses, reserved bits dropped
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tx_enable_reg  <= liu_regs_pkg::RESET_CHAN6;
         rx_enable_reg  <= liu_regs_pkg::RESET_CHAN6;
         global_ien_reg <= liu_regs_pkg::RESET_CHAN6;
      end else if (wr_take) begin
         if (addr_in == liu_regs_pkg::ADDR_TX_ENABLE) begin
            tx_enable_reg <= data_in[5:0];
         end else if (addr_in == liu_regs_pkg::ADDR_RX_ENABLE) begin
            rx_enable_reg <= data_in[5:0];
         end else if (addr_in == liu_regs_pkg::ADDR_GLOBAL_IEN) begin
            global_ien_reg <= data_in[5:0];
         end
      end
   end

   // pending follows channel summaries; a read clears, a live source sets again
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         global_pend_reg <= liu_regs_pkg::RESET_CHAN6;
      end else if (rd_take && addr_in == liu_regs_pkg::ADDR_GLOBAL_PEND) begin
         global_pend_reg <= chan_irq;
      end else begin
         global_pend_reg <= global_pend_reg | chan_irq;
      end
   end

   // interrupt pin is a level of enabled channel summaries, so it
   // releases after software has read the source status clear, or has cleared the channel's enable at 0x60
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         int_n_reg <= 1'b1;
      end else begin
         int_n_reg <= ~|(chan_irq & global_ien_reg);
      end
   end

   // transmitter needs both the register bit and its pin
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         transmit_on_reg <= liu_regs_pkg::RESET_CHAN6;
      end else begin
         transmit_on_reg <= tx_enable_reg & transmit_enable_pin_in;
      end
   end

   // ***************************************************************
   // read decode
   // ***************************************************************
   always_comb begin
      if (addr_in == liu_regs_pkg::ADDR_TX_ENABLE) begin
         read_mux = {2'b00, tx_enable_reg};
      end else if (addr_in == liu_regs_pkg::ADDR_RX_ENABLE) begin
         read_mux = {2'b00, rx_enable_reg};
      end else if (addr_in == liu_regs_pkg::ADDR_GLOBAL_IEN) begin
         read_mux = {2'b00, global_ien_reg};
      end else if (addr_in == liu_regs_pkg::ADDR_GLOBAL_PEND) begin
         read_mux = {2'b00, global_pend_reg};
      end else if (addr_in == liu_regs_pkg::ADDR_IDENTITY) begin
         read_mux = IDENTITY_CODE;
      end else if (addr_in == liu_regs_pkg::ADDR_VERSION) begin
         read_mux = VERSION_CODE;
      end else if (chan_hit(addr_in)) begin
         read_mux = chan_rdata[addr_in[6:4]];
      end else begin
         read_mux = liu_regs_pkg::RESET_BYTE;   // unmapped reads zero
      end
   end

   // ***************************************************************
   // channel blocks
   // ***************************************************************
   for (genvar g = 0; g < liu_regs_pkg::NUM_CHAN; g++) begin : g_chan
      liu_chan_if chan_bus ();
      // strobes only reach the block the upper nibble selects
      assign chan_bus.wr_strobe = wr_take && chan_hit(addr_in) && (addr_in[6:4] == 3'(g));
      assign chan_bus.rd_strobe = rd_take && chan_hit(addr_in) && (addr_in[6:4] == 3'(g));
      assign chan_bus.offset    = addr_in[3:0];
      assign chan_bus.wdata     = data_in;
      assign chan_rdata[g]      = chan_bus.rdata;
      assign chan_irq[g]        = chan_bus.irq;
      assign tx_control_out[g*8 +: 8]     = chan_bus.tx_ctrl;
      assign rx_control_out[g*8 +: 8]     = chan_bus.rx_ctrl;
      assign block_control_out[g*8 +: 8]  = chan_bus.blk_ctrl;
      assign jitter_control_out[g*8 +: 8] = chan_bus.ja_ctrl;

      liu_channel_regs u_chan (
         .clock_in      (clock_in),
         .rst_n_in      (rst_n_in),
         .bus           (chan_bus.chan),
         .alarm_in      (alarm_in[g*7 +: 7]),
         .prbs_error_in (prbs_error_in[g])
      );
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign data_out        = data_reg;
   assign data_oe_out     = data_oe_reg;
   assign rdy_n_out       = rdy_n_reg;
   assign int_n_out       = int_n_reg;
   assign transmit_on_out = transmit_on_reg;
   assign receive_on_out  = rx_enable_reg;

endmodule : liu_global_register_bank
`default_nettype wire

// file: liu_regs_chk.sv
// concurrent checks on the register bank host port, interrupt and enables
`timescale 1ns/1ps
`default_nettype none
module liu_regs_chk (
   // clock, reset and host port
   input wire logic       clock_in, rst_n_in, cs_n_in, rd_n_in, wr_n_in,
   input wire logic       rdy_n_out, data_oe_out, int_n_out,
   input wire logic [7:0] data_out,
   // channel enables
   input wire logic [5:0] transmit_enable_pin_in, transmit_on_out, receive_on_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // ready low while a strobe is still held, or the strobe has just gone
   sequence s_held; !rdy_n_out && !(rd_n_in && wr_n_in); endsequence
   sequence s_freed; !rdy_n_out && rd_n_in && wr_n_in; endsequence
   a_reset_dflt: assert property ($rose(rst_n_in) |-> rdy_n_out && int_n_out && !data_oe_out
      && transmit_on_out == 6'h00 && receive_on_out == 6'h00) else $error("outputs not at defaults");
   a_rdy_cause: assert property ($fell(rdy_n_out)
      |-> !$past(cs_n_in) && !($past(rd_n_in) && $past(wr_n_in)))
      else $error("ready without a strobe under select");
   a_rdy_stands: assert property (s_held |=> !rdy_n_out) else $error("ready dropped early");
   a_rdy_ends: assert property (s_freed |=> rdy_n_out) else $error("ready kept after release");
   a_oe_read: assert property ($fell(rdy_n_out) && !rd_n_in |-> data_oe_out) else $error("no drive on read");
   a_oe_write: assert property ($fell(rdy_n_out) && rd_n_in |-> !data_oe_out) else $error("drive on write");
   a_oe_in_ack: assert property (data_oe_out |-> !rdy_n_out) else $error("bus driven outside a cycle");
   a_data_hold: assert property (data_oe_out && $past(data_oe_out) |-> $stable(data_out))
      else $error("read data moved");
   a_tx_gate: assert property ((transmit_on_out & ~$past(transmit_enable_pin_in)) == 6'h00)
      else $error("transmitter on without pin");
   a_int_release: assert property ($rose(int_n_out) |-> !$past(cs_n_in, 2))
      else $error("interrupt released without access");
endmodule : liu_regs_chk
bind liu_global_register_bank liu_regs_chk u_liu_regs_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
   .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in), .rdy_n_out(rdy_n_out), .data_out(data_out),
   .data_oe_out(data_oe_out), .int_n_out(int_n_out), .transmit_enable_pin_in(transmit_enable_pin_in),
   .transmit_on_out(transmit_on_out), .receive_on_out(receive_on_out));
`default_nettype wire

// file: liu_host_model.sv
// host processor model: select, strobes, address and write data
`timescale 1ns/1ps
`default_nettype none
module liu_host_model (
   input  wire logic       clock_in, rdy_n_in,
   input  wire logic [7:0] data_in,
   output logic            cs_n_out, rd_n_out, wr_n_out,
   output logic      [7:0] addr_out, data_out
);
   initial {cs_n_out, rd_n_out, wr_n_out, addr_out, data_out} = {3'h7, 16'h0000};
   // one access: hold everything until ready is seen low at a rising edge, giving up after 16 rising edges
   task acc(input bit w, input logic [7:0] a, d, output logic [7:0] q, output bit ok);
      ok = 1'b0;
      @(negedge clock_in);
      {addr_out, data_out, cs_n_out, rd_n_out, wr_n_out} <= {a, d, 1'b0, w, !w};
      for (int i = 0; i < 16 && !ok; i++) begin
         @(posedge clock_in);
         ok = (rdy_n_in === 1'b0);
      end
      q = data_in;
      @(negedge clock_in);
      {cs_n_out, rd_n_out, wr_n_out} <= 3'h7; // release, select high before next command
      data_out <= ~d; // released bus never shows the last value
   endtask : acc
endmodule : liu_host_model
`default_nettype wire

// file: tb_liu_global_register_bank.sv
// self-checking bench of the register bank through its host port
`timescale 1ns/1ps
`default_nettype none
module tb_liu_global_register_bank;
   localparam logic [7:0] ID = 8'h3C; // arbitrary value
   localparam logic [7:0] VER = 8'h07; // arbitrary value
   logic clock_in = 1'b0, rst_n = 1'b0, cs_n, rd_n, wr_n, rdy_n, int_n;
   logic [7:0] addr, wdata, rdata;
   logic [5:0] pin = 6'h00, prbs = 6'h00, tx_on, rx_on;
   logic [41:0] alarm = 42'h0;
   logic [47:0] tx_ctl, rx_ctl, blk_ctl, ja_ctl;
   logic [7:0] msk [4] = '{8'h37, 8'h3F, 8'h7F, 8'h1F}; // implemented bits of offsets 4 to 7
   int err_count = 0, compares = 0;
   logic [15:0] dflt [7] = '{16'h0000, 16'h0800, 16'h6000, 16'h6100, {8'h6E, ID}, {8'h6F, VER}, 16'h6200};
   initial forever #5 clock_in = ~clock_in;
   liu_host_model u_liu_host_model (.clock_in(clock_in), .rdy_n_in(rdy_n), .data_in(rdata),
      .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .data_out(wdata));
   liu_global_register_bank #(.IDENTITY_CODE(ID), .VERSION_CODE(VER)) u_liu_global_register_bank (
      .clock_in(clock_in), .rst_n_in(rst_n), .addr_in(addr), .data_in(wdata), .data_out(rdata),
      .data_oe_out(), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n), .rdy_n_out(rdy_n),
      .int_n_out(int_n), .transmit_enable_pin_in(pin), .transmit_on_out(tx_on), .receive_on_out(rx_on),
      .alarm_in(alarm), .prbs_error_in(prbs), .tx_control_out(tx_ctl), .rx_control_out(rx_ctl),
      .block_control_out(blk_ctl), .jitter_control_out(ja_ctl));
   task close_out();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : close_out
   task chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // bus access; a hung cycle counts and ends the run
   task acc(input bit w, input logic [7:0] a, d, e);
      logic [7:0] q;
      bit ok;
      u_liu_host_model.acc(w, a, d, q, ok);
      if (!ok) begin
         err_count++;
         $display("mismatch ready expected 0 seen 1");
         close_out();
      end else if (!w) chk("register read", e, q);
   endtask : acc
   task pulse(input int c);
      @(negedge clock_in) prbs[c] = 1'b1;
      @(negedge clock_in) prbs = 6'h00;
      repeat (3) @(negedge clock_in);
   endtask : pulse
   initial begin
      repeat (10) @(negedge clock_in);
      rst_n = 1'b1;
      foreach (dflt[i]) acc(0, dflt[i][15:8], 8'h00, dflt[i][7:0]);
      acc(1, 8'h6E, 8'h00, 8'h00);
      acc(0, 8'h6E, 8'h00, ID);
      acc(1, 8'h00, 8'hFF, 8'h00);
      acc(0, 8'h00, 8'h00, 8'h3F);
      pin = 6'h2A;
      @(negedge clock_in) chk("transmit on", 8'h2A, {2'b00, tx_on});
      acc(1, 8'h08, 8'hD5, 8'h00);
      chk("receive on", 8'h15, {2'b00, rx_on});
      for (int n = 0; n < 6; n++) begin
         for (int k = 0; k < 4; k++) begin
            acc(1, 8'(n * 16 + 4 + k), 8'hFF, 8'h00);
            acc(0, 8'(n * 16 + 4 + k), 8'h00, msk[k]);
         end
         chk("tx control", 8'h37, tx_ctl[n * 8 +: 8]);
         chk("rx control", 8'h3F, rx_ctl[n * 8 +: 8]);
         chk("block control", 8'h7F, blk_ctl[n * 8 +: 8]);
         chk("jitter control", 8'h1F, ja_ctl[n * 8 +: 8]);
      end
      acc(1, 8'h10, 8'hFF, 8'h00);
      acc(0, 8'h10, 8'h00, 8'h00);
      alarm[6:0] = 7'h55;
      acc(0, 8'h03, 8'h00, 8'h55);
      acc(1, 8'h31, 8'h10, 8'h00);
      pulse(3);
      chk("interrupt masked", 8'h01, {7'h00, int_n});
      acc(0, 8'h32, 8'h00, 8'h10);
      acc(1, 8'h60, 8'h08, 8'h00);
      pulse(3);
      chk("interrupt low", 8'h00, {7'h00, int_n});
      acc(0, 8'h32, 8'h00, 8'h10);
      acc(0, 8'h32, 8'h00, 8'h00);
      chk("interrupt freed", 8'h01, {7'h00, int_n});
      acc(0, 8'h61, 8'h00, 8'h08);
      acc(1, 8'h61, 8'hFF, 8'h00);
      acc(0, 8'h61, 8'h00, 8'h00);
      pulse(2);
      acc(0, 8'h22, 8'h00, 8'h00);
      acc(0, 8'h3A, 8'h00, 8'h00);
      acc(0, 8'h3C, 8'h00, 8'h02);
      acc(0, 8'h3B, 8'h00, 8'h02);
      // error on every cycle past the count limit: must saturate, not wrap
      acc(1, 8'h41, 8'h20, 8'h00);
      @(negedge clock_in) prbs[4] = 1'b1;
      repeat (65540) @(negedge clock_in);
      prbs = 6'h00;
      acc(0, 8'h42, 8'h00, 8'h20);
      acc(0, 8'h4A, 8'h00, 8'hFF);
      acc(0, 8'h4B, 8'h00, 8'hFF);
      rst_n = 1'b0;
      repeat (liu_regs_pkg::RESET_MIN_CYCLES) @(negedge clock_in);
      rst_n = 1'b1;
      acc(0, 8'h00, 8'h00, 8'h00);
      acc(0, 8'h34, 8'h00, 8'h00);
      close_out();
   end
endmodule : tb_liu_global_register_bank
`default_nettype wire
